/* core/hrf_consts.vh */
`ifndef HRF_CONSTS_VH
`define HRF_CONSTS_VH
// wishbone word offsets (byte addresses)
`define HRF_ADR_SIG_FIFO    8'h00
`define HRF_ADR_SIG_IRQ     8'h04
`define HRF_ADR_SIG_CMD     8'h08
`define HRF_ADR_SIG_CNTL    8'h0C
`define HRF_ADR_SIG_CNTH    8'h10
`define HRF_ADR_SIG_CFG     8'h14
`define HRF_ADR_BRR_FIFO    8'h20
`define HRF_ADR_BRR_IRQ     8'h24
`define HRF_ADR_BRR_CMD     8'h28
`define HRF_ADR_BRR_CNTL    8'h2C
`define HRF_ADR_BRR_CNTH    8'h30
`define HRF_ADR_BRR_CFG     8'h34
// command bits
`define HRF_CMD_ACK_BIT     7
`define HRF_CMD_RESET_BIT   6
// interrupt status bits
`define HRF_IRQ_PF_BIT      7
`define HRF_IRQ_ME_BIT      6
`define HRF_IRQ_FL_BIT      5
// status byte bits
`define HRF_ST_VFR_BIT      7
`define HRF_ST_RDO_BIT      6
`define HRF_ST_CRC_BIT      5
`define HRF_ST_RAB_BIT      4
// count high register overflow bit
`define HRF_CNT_OV_BIT      4
// block threshold reset codes
`define HRF_SIG_THR_RST     2'h0
`define HRF_BRR_THR_RST     1'h0
// fifo depths
`define HRF_SIG_DEPTH       64
`define HRF_BRR_DEPTH       128
`define HRF_QUEUE_DEPTH     4
`endif

/* core/hrf_receive_fifo.v */
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "hrf_consts.vh"

module hrf_rx_channel #(
    parameter DEPTH  = 64,
    parameter AW     = 6,
    parameter THRW   = 2,
    parameter QDEPTH = 4
) (
    input  wire            clk,
    input  wire            nrst,
    input  wire            rxValid,
    input  wire [7:0]      rxData,
    input  wire            rxEnd,
    input  wire [7:0]      rxStatus,
    input  wire            popFifo,
    input  wire            ackCmd,
    input  wire            resetCmd,
    input  wire            irqRead,
    input  wire [THRW-1:0] thrCode,
    output reg  [7:0]      fifoData,
    output wire [7:0]      irqStatus,
    output wire [11:0]     count,
    output wire            countOv,
    output wire            irqPending
);
    localparam QW = 2;
    reg [7:0]      mem [0:DEPTH-1];
    reg [AW:0]     wrPtr_q, relPtr_q, rdPtr_q, blkBase_q;
    reg [12:0]     cnt_q;
    reg [5:0]      blkCnt_q;
    reg            inFrame_q, dropping_q, lost_q, statPend_q;
    reg [7:0]      statByte_q;
    reg [THRW-1:0] thrAct_q;
    reg            pf_q, me_q, fl_q, shown_q;
    // interrupt queue entries: type, frame count, block end pointer
    reg            qMe   [0:QDEPTH-1];
    reg [12:0]     qCnt  [0:QDEPTH-1];
    reg [AW:0]     qEnd  [0:QDEPTH-1];
    reg [QW:0]     qWr_q, qRd_q;
    reg [12:0]     curCnt_q;
    reg            curMe_q;
    reg [AW:0]     curEnd_q;
    wire [5:0]     blkSize = (THRW == 2) ? (6'd32 >> thrAct_q) : (6'd16 >> thrAct_q);
    wire [AW:0]    used = wrPtr_q - relPtr_q;
    // one byte and one queue slot stay free so a frame's status byte always lands
    wire           full = (used >= DEPTH[AW:0] - 1'b1);
    wire           qEmpty = (qWr_q == qRd_q);
    wire           qFull = ((qWr_q - qRd_q) >= QDEPTH[QW:0] - 1'b1);
    wire           wrByte = (rxValid & ~dropping_q & ~full & ~qFull) | statPend_q;
    wire [7:0]     wrVal = statPend_q ? statByte_q : rxData;
    // the status byte fills a block like a data byte does
    wire           blkDone = wrByte & (blkCnt_q + 6'd1 == blkSize);
    wire           pushPf = blkDone & ~statPend_q;
    wire           pushMe = statPend_q;
    wire [12:0]    cntNext = (cnt_q == 13'h0FFF) ? 13'h1FFF : ((cnt_q[12]) ? cnt_q : cnt_q + 13'd1);

    assign count      = curCnt_q[11:0];
    assign countOv    = curCnt_q[12];
    assign irqStatus  = {pf_q, me_q, fl_q, 5'h00};
    assign irqPending = pf_q | me_q | fl_q;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPtr_q      <= {(AW+1){1'b0}};
            relPtr_q     <= {(AW+1){1'b0}};
            rdPtr_q      <= {(AW+1){1'b0}};
            blkBase_q    <= {(AW+1){1'b0}};
            cnt_q        <= 13'h0000;
            blkCnt_q     <= 6'h00;
            inFrame_q    <= 1'b0;
            dropping_q   <= 1'b0;
            lost_q       <= 1'b0;
            statPend_q   <= 1'b0;
            statByte_q   <= 8'h00;
            thrAct_q     <= {THRW{1'b0}};
            pf_q         <= 1'b0;
            me_q         <= 1'b0;
            fl_q         <= 1'b0;
            shown_q      <= 1'b0;
            qWr_q        <= {(QW+1){1'b0}};
            qRd_q        <= {(QW+1){1'b0}};
            curCnt_q     <= 13'h0000;
            curMe_q      <= 1'b0;
            curEnd_q     <= {(AW+1){1'b0}};
            fifoData     <= 8'h00;
        end
        else
        begin
            if (irqRead)
            begin
                pf_q <= 1'b0;
                me_q <= 1'b0;
                fl_q <= 1'b0;
            end
            if (resetCmd)
            begin
                // pending flags survive
                wrPtr_q      <= {(AW+1){1'b0}};
                relPtr_q     <= {(AW+1){1'b0}};
                rdPtr_q      <= {(AW+1){1'b0}};
                blkBase_q    <= {(AW+1){1'b0}};
                cnt_q        <= 13'h0000;
                blkCnt_q     <= 6'h00;
                inFrame_q    <= 1'b0;
                dropping_q   <= 1'b0;
                lost_q       <= 1'b0;
                statPend_q   <= 1'b0;
                shown_q      <= 1'b0;
                qWr_q        <= {(QW+1){1'b0}};
                qRd_q        <= {(QW+1){1'b0}};
                curCnt_q     <= 13'h0000;
                thrAct_q     <= thrCode;
            end
            else
            begin
                // receive side, one byte per strobe
                if (wrByte)
                begin
                    mem[wrPtr_q[AW-1:0]] <= wrVal;
                    wrPtr_q <= wrPtr_q + 1'b1;
                end
                if (statPend_q)
                begin
                    // status byte just closed the stored frame
                    statPend_q <= 1'b0;
                end
                if (rxValid & ~statPend_q)
                begin
                    if (!inFrame_q & (full | qFull))
                        dropping_q <= 1'b1;
                    if (!inFrame_q & !dropping_q & !(full | qFull))
                        inFrame_q <= 1'b1;
                    if (inFrame_q & ~wrByte)
                        lost_q <= 1'b1;
                    if (wrByte)
                    begin
                        cnt_q    <= cntNext;
                        blkCnt_q <= blkDone ? 6'h00 : blkCnt_q + 6'd1;
                    end
                    if (rxEnd)
                    begin
                        if (dropping_q | (!inFrame_q & (full | qFull)))
                        begin
                            fl_q       <= 1'b1;
                            dropping_q <= 1'b0;
                        end
                        else
                        begin
                            // status byte follows last data byte
                            statByte_q <= {rxStatus[7], lost_q | ~wrByte | full, rxStatus[5:0]};
                            statPend_q <= 1'b1;
                        end
                        inFrame_q <= 1'b0;
                        lost_q    <= 1'b0;
                    end
                end
                // queue push
                if (pushPf | pushMe)
                begin
                    qMe[qWr_q[QW-1:0]]  <= pushMe;
                    qCnt[qWr_q[QW-1:0]] <= cntNext;
                    qEnd[qWr_q[QW-1:0]] <= wrPtr_q + 1'b1;
                    qWr_q <= qWr_q + 1'b1;
                end
                if (pushMe)
                begin
                    cnt_q    <= 13'h0000;
                    blkCnt_q <= 6'h00;
                end
                // present next queued event only when none is shown
                if (!shown_q & !qEmpty)
                begin
                    shown_q   <= 1'b1;
                    curMe_q   <= qMe[qRd_q[QW-1:0]];
                    curCnt_q  <= qCnt[qRd_q[QW-1:0]];
                    curEnd_q  <= qEnd[qRd_q[QW-1:0]];
                    qRd_q     <= qRd_q + 1'b1;
                    rdPtr_q   <= blkBase_q;
                    if (qMe[qRd_q[QW-1:0]])
                        me_q <= 1'b1;
                    else
                        pf_q <= 1'b1;
                end
                // host pop; stays on last byte past the end
                if (popFifo & shown_q)
                begin
                    fifoData <= mem[rdPtr_q[AW-1:0]];
                    if (rdPtr_q + 1'b1 != curEnd_q)
                        rdPtr_q <= rdPtr_q + 1'b1;
                end
                if (ackCmd)
                begin
                    thrAct_q <= thrCode;
                    if (shown_q)
                    begin
                        // unread data discarded
                        relPtr_q  <= curEnd_q;
                        blkBase_q <= curEnd_q;
                        shown_q   <= 1'b0;
                        if (curMe_q)
                            curCnt_q <= 13'h0000;
                    end
                end
            end
        end
    end
endmodule // hrf_rx_channel

module hrf_receive_fifo (
    input  wire        clk,
    input  wire        nrst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        wb_err_o,
    input  wire        sigRxValid,
    input  wire [7:0]  sigRxData,
    input  wire        sigRxEnd,
    input  wire [7:0]  sigRxStatus,
    input  wire        brrRxValid,
    input  wire [7:0]  brrRxData,
    input  wire        brrRxEnd,
    input  wire [7:0]  brrRxStatus,
    output wire        sigIrqPending,
    output wire        brrIrqPending,
    output wire        sigRxResetPulse,
    output wire        brrRxResetPulse
);
    reg  [1:0]  sigThr_q;
    reg         brrThr_q;
    wire        req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr  = req & wb_we_i & wb_sel_i[0];
    wire        rd  = req & ~wb_we_i;
    // fifo window decode ignores low address bits
    wire        sigWin = (wb_adr_i[7:2] == `HRF_ADR_SIG_FIFO >> 2);
    wire        brrWin = (wb_adr_i[7:2] == `HRF_ADR_BRR_FIFO >> 2);
    wire        sigCmdW = wr & (wb_adr_i == `HRF_ADR_SIG_CMD);
    wire        brrCmdW = wr & (wb_adr_i == `HRF_ADR_BRR_CMD);
    wire        sigAck = sigCmdW & wb_dat_i[`HRF_CMD_ACK_BIT];
    wire        sigRst = sigCmdW & wb_dat_i[`HRF_CMD_RESET_BIT];
    wire        brrAck = brrCmdW & wb_dat_i[`HRF_CMD_ACK_BIT];
    wire        brrRst = brrCmdW & wb_dat_i[`HRF_CMD_RESET_BIT];
    // flags clear at the ack edge, after the read has returned them
    wire        irqRd    = wb_cyc_i & wb_stb_i & wb_ack_o & ~wb_we_i;
    wire        sigIrqRd = irqRd & (wb_adr_i == `HRF_ADR_SIG_IRQ);
    wire        brrIrqRd = irqRd & (wb_adr_i == `HRF_ADR_BRR_IRQ);
    wire [7:0]  sigData, sigIrq, brrData, brrIrq;
    wire [11:0] sigCnt, brrCnt;
    wire        sigOv, brrOv;

    assign wb_err_o        = 1'b0;
    assign sigRxResetPulse = sigRst;
    assign brrRxResetPulse = brrRst;

    hrf_rx_channel #(.DEPTH(`HRF_SIG_DEPTH), .AW(6), .THRW(2), .QDEPTH(`HRF_QUEUE_DEPTH)) uSig (
        .clk        (clk),
        .nrst       (nrst),
        .rxValid    (sigRxValid),
        .rxData     (sigRxData),
        .rxEnd      (sigRxEnd),
        .rxStatus   (sigRxStatus),
        .popFifo    (rd & sigWin),
        .ackCmd     (sigAck),
        .resetCmd   (sigRst),
        .irqRead    (sigIrqRd),
        .thrCode    (sigThr_q),
        .fifoData   (sigData),
        .irqStatus  (sigIrq),
        .count      (sigCnt),
        .countOv    (sigOv),
        .irqPending (sigIrqPending)
    );

    hrf_rx_channel #(.DEPTH(`HRF_BRR_DEPTH), .AW(7), .THRW(1), .QDEPTH(`HRF_QUEUE_DEPTH)) uBrr (
        .clk        (clk),
        .nrst       (nrst),
        .rxValid    (brrRxValid),
        .rxData     (brrRxData),
        .rxEnd      (brrRxEnd),
        .rxStatus   (brrRxStatus),
        .popFifo    (rd & brrWin),
        .ackCmd     (brrAck),
        .resetCmd   (brrRst),
        .irqRead    (brrIrqRd),
        .thrCode    (brrThr_q),
        .fifoData   (brrData),
        .irqStatus  (brrIrq),
        .count      (brrCnt),
        .countOv    (brrOv),
        .irqPending (brrIrqPending)
    );

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sigThr_q <= `HRF_SIG_THR_RST;
            brrThr_q <= `HRF_BRR_THR_RST;
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req;
            if (wr & (wb_adr_i == `HRF_ADR_SIG_CFG))
                sigThr_q <= wb_dat_i[1:0];
            if (wr & (wb_adr_i == `HRF_ADR_BRR_CFG))
                brrThr_q <= wb_dat_i[0];
        end
    end

    // fifo data appears one cycle after pop, so read mux uses registered address
    reg [7:0] adr_q;
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            adr_q <= 8'h00;
        else
            adr_q <= wb_adr_i;
    end

    always @*
    begin
        wb_dat_o = 32'h00000000;
        if (adr_q[7:2] == `HRF_ADR_SIG_FIFO >> 2)
            wb_dat_o = {24'h000000, sigData};
        else if (adr_q[7:2] == `HRF_ADR_BRR_FIFO >> 2)
            wb_dat_o = {24'h000000, brrData};
        else
        begin
            case (adr_q)
                `HRF_ADR_SIG_IRQ:  wb_dat_o = {24'h000000, sigIrq};
                `HRF_ADR_SIG_CNTL: wb_dat_o = {24'h000000, sigCnt[7:0]};
                `HRF_ADR_SIG_CNTH: wb_dat_o = {27'h0000000, sigOv, sigCnt[11:8]};
                `HRF_ADR_SIG_CFG:  wb_dat_o = {30'h00000000, sigThr_q};
                `HRF_ADR_BRR_IRQ:  wb_dat_o = {24'h000000, brrIrq};
                `HRF_ADR_BRR_CNTL: wb_dat_o = {24'h000000, brrCnt[7:0]};
                `HRF_ADR_BRR_CNTH: wb_dat_o = {27'h0000000, brrOv, brrCnt[11:8]};
                `HRF_ADR_BRR_CFG:  wb_dat_o = {31'h00000000, brrThr_q};
                default:           wb_dat_o = 32'h00000000;
            endcase
        end
    end
endmodule // hrf_receive_fifo

/* dv/hrf_receive_fifo_assertions.sv */
`timescale 1ns/1ps
module hrf_rx_chk (
    input wire        clk,
    input wire        nrst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        sigIrqPending,
    input wire        sigRxResetPulse,
    input wire        brrRxResetPulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire rdAck = wb_ack_o && !wb_we_i;
    wire cmdWr = wb_cyc_i && wb_we_i && wb_adr_i == 8'h08 && wb_dat_i[6];
    wire cmdWrB = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h28 && wb_dat_i[6];
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without cycle");
    chk_fifo_lane: assert property (rdAck && wb_adr_i[7:2] == 6'h00 |-> wb_dat_o[31:8] == 24'h0)
        else $error("fifo data outside low lane");
    chk_count_width: assert property (rdAck && wb_adr_i == 8'h10 |-> wb_dat_o[31:5] == 27'h0)
        else $error("count high too wide");
    chk_irq_clear: assert property ($fell(sigIrqPending) |-> $past(wb_cyc_i && !wb_we_i && wb_adr_i == 8'h04))
        else $error("pending dropped without status read");
    chk_reset_keep: assert property (wb_ack_o && cmdWr && $past(sigIrqPending) |-> sigIrqPending)
        else $error("receiver reset cleared pending");
    chk_pulse_cause: assert property (sigRxResetPulse |-> cmdWr && wb_stb_i)
        else $error("reset pulse without command");
    chk_brr_pulse_cause: assert property (brrRxResetPulse |-> cmdWrB)
        else $error("bearer reset pulse without command");
endmodule // hrf_rx_chk

bind hrf_receive_fifo hrf_rx_chk u_chk (
    .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sigIrqPending(sigIrqPending), .sigRxResetPulse(sigRxResetPulse), .brrRxResetPulse(brrRxResetPulse)
);

/* dv/hrf_rx_src.sv */
`timescale 1ns/1ps
module hrf_rx_src (
    input  wire       clk,
    output reg        rxValid,
    output reg  [7:0] rxData,
    output reg        rxEnd,
    output reg  [7:0] rxStatus
);
    reg [7:0] b;
    initial
    begin
        rxValid = 1'b0;
        rxData = 8'h00;
        rxEnd = 1'b0;
        rxStatus = 8'h00;
    end
    // one byte every fourth cycle; lines inverted between bytes so stale data never looks valid
    task send(input [7:0] n, input [7:0] base, input [7:0] st);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1)
            begin
                b = base + i[7:0];
                @(posedge clk);
                rxValid <= 1'b1;
                rxData <= b;
                rxEnd <= (i == n - 1);
                rxStatus <= st;
                @(posedge clk);
                rxValid <= 1'b0;
                rxEnd <= 1'b0;
                rxData <= ~b;
                rxStatus <= ~st;
                repeat (2) @(posedge clk);
            end
        end
    endtask
endmodule // hrf_rx_src

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
    reg         clk, nrst, cyc, stb, we;
    reg  [7:0]  adr;
    reg  [31:0] wdat, rnd;
    wire [31:0] rdat;
    wire        ack, sigV, sigE, brrV, brrE, sigPend, brrPend;
    wire [7:0]  sigD, sigS, brrD, brrS;
    reg  [71:0] expQ[$];
    reg  [71:0] e;
    integer     fails, n_checks, t;

    hrf_receive_fifo u_hrf_receive_fifo (
        .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(),
        .sigRxValid(sigV), .sigRxData(sigD), .sigRxEnd(sigE), .sigRxStatus(sigS),
        .brrRxValid(brrV), .brrRxData(brrD), .brrRxEnd(brrE), .brrRxStatus(brrS),
        .sigIrqPending(sigPend), .brrIrqPending(brrPend), .sigRxResetPulse(), .brrRxResetPulse());
    hrf_rx_src u_hrf_rx_src_sig (.clk(clk), .rxValid(sigV), .rxData(sigD), .rxEnd(sigE), .rxStatus(sigS));
    hrf_rx_src u_hrf_rx_src_brr (.clk(clk), .rxValid(brrV), .rxData(brrD), .rxEnd(brrE), .rxStatus(brrS));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [31:0] pendOf(input [7:0] o);
        pendOf = {31'h0, o[5] ? brrPend : sigPend};
    endfunction
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp)
            begin
                fails = fails + 1;
                $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d fails %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task tmo;
        begin
            fails = fails + 1;
            $display("[ERR] wait exp done seen timeout");
            wrap_up;
        end
    endtask
    // read results are checked here, in request order
    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0)
        begin
            if (expQ.size() == 0)
                check("spare read", 32'h1, 32'h0);
            else
            begin
                e = expQ.pop_front();
                check($sformatf("rd %h", e[71:64]), rdat & e[63:32], e[31:0]);
            end
        end
    task wb(input w, input [7:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            k = 0;
            @(posedge clk);
            while (ack !== 1'b1 && k < 50)
            begin
                @(posedge clk);
                k = k + 1;
            end
            if (ack !== 1'b1)
                tmo;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] x, input [31:0] m);
        begin
            expQ.push_back({a, m, x});
            wb(1'b0, a, 32'h0);
        end
    endtask
    task waitp(input [7:0] o);
        integer k;
        begin
            k = 0;
            while (pendOf(o) !== 32'h1 && k < 2000)
            begin
                @(posedge clk);
                k = k + 1;
            end
            if (pendOf(o) !== 32'h1)
                tmo;
        end
    endtask
    // one frame of n data bytes on channel o, read block by block with threshold blk
    task frame(input [7:0] o, input [7:0] blk, input [7:0] n);
        integer left, idx, j, q;
        reg [7:0] st, base;
        begin
            rnd = lfsr(rnd);
            st = rnd[7:0];
            base = rnd[15:8];
            if (o[5])
                u_hrf_rx_src_brr.send(n, base, st);
            else
                u_hrf_rx_src_sig.send(n, base, st);
            left = n + 1;
            idx = 0;
            while (left > 0)
            begin
                waitp(o);
                rd(o + 8'h04, (left > blk) ? 32'h80 : 32'h40, 32'hE0);
                if (left <= blk)
                begin
                    rd(o + 8'h0C, {24'h0, n} + 32'h1, 32'hFF);
                    rd(o + 8'h10, 32'h0, 32'h1F);
                end
                q = (left > blk) ? blk : left;
                for (j = 0; j < q; j = j + 1)
                begin
                    rnd = lfsr(rnd);
                    rd(o + {6'h0, rnd[1:0]}, (idx == n) ? st & 8'hBF : base + idx[7:0], 32'hFF);
                    idx = idx + 1;
                end
                if (left <= blk)
                    rd(o, st & 8'hBF, 32'hFF);
                check("pending", pendOf(o), 32'h0);
                wb(1'b1, o + 8'h08, 32'h80);
                if (left > blk)
                begin
                    repeat (2) @(posedge clk);
                    check("pending", pendOf(o), 32'h1);
                end
                left = left - blk;
            end
            rd(o + 8'h0C, 32'h0, 32'hFF);
        end
    endtask
    initial
    begin
        {nrst, cyc, stb, we, adr, wdat} = 0;
        rnd = 32'h1ba640d3;
        fails = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h14, 32'h0, 32'hFFFFFFFF);
        rd(8'h34, 32'h0, 32'hFFFFFFFF);
        rd(8'h18, 32'h0, 32'hFFFFFFFF);
        wb(1'b1, 8'h08, 32'h40);
        wb(1'b1, 8'h28, 32'h40);
        frame(8'h00, 8'd32, 8'd32);
        frame(8'h20, 8'd16, 8'd16);
        $display("test 1 done");
        for (t = 1; t < 4; t = t + 1)
        begin
            wb(1'b1, 8'h14, t);
            wb(1'b1, 8'h08, 32'h40);
            frame(8'h00, 8'd32 >> t, 8'd32 >> t);
        end
        frame(8'h00, 8'd4, 8'd7);
        wb(1'b1, 8'h14, 32'h0);
        frame(8'h00, 8'd4, 8'd4);
        wb(1'b1, 8'h34, 32'h1);
        wb(1'b1, 8'h28, 32'h40);
        frame(8'h20, 8'd8, 8'd8);
        $display("test 2 done");
        wb(1'b1, 8'h08, 32'h40);
        u_hrf_rx_src_sig.send(8'd31, 8'h10, 8'hA0);
        u_hrf_rx_src_sig.send(8'd31, 8'h30, 8'hA0);
        u_hrf_rx_src_sig.send(8'd3, 8'h50, 8'hA0);
        repeat (20) @(posedge clk);
        wb(1'b1, 8'h08, 32'h40);
        check("pending", pendOf(8'h00), 32'h1);
        rd(8'h04, 32'h20, 32'h20);
        frame(8'h00, 8'd32, 8'd3);
        $display("test 3 done");
        repeat (4) @(posedge clk);
        check("queue", expQ.size(), 32'h0);
        wrap_up;
    end
endmodule // tb
